// [verilog/rate_half_convolutional_encoder.v]
// rate one-half constraint-length-three convolutional encoder with input fifo
`timescale 1ns/1ns
`include "conv_enc_defs.vh"
module rate_half_convolutional_encoder (
  input wire sys_clk,
  input wire rst_b,
  input wire sync_clear,
  input wire systematic_mode,
  input wire data_bit,
  input wire data_valid,
  output wire data_ready,
  output reg code_bit,
  output reg code_valid,
  output reg code_first,
  input wire code_ready,
  output reg mode_active
);
  // one-hot pair sequencer states
  localparam ST_IDLE = 2'h1;
  localparam ST_SECOND = 2'h2;

  wire rst_sync_b;
  wire fifo_bit;
  wire fifo_valid;
  wire fifo_ready;

  // handshake qualifiers
  wire out_free;
  wire take;
  wire send_second;

  // encoder window, newest bit in the top stage
  reg [`STAGE_COUNT-1:0] shift_reg;
  reg [`STAGE_COUNT-1:0] shift_next;
  wire [`STAGE_COUNT-1:0] window;
  wire first_parity;
  wire second_parity;

  // generator set, latched only at a clear
  reg [`STAGE_COUNT-1:0] gen_first_reg;
  reg [`STAGE_COUNT-1:0] gen_first_next;
  reg mode_next;

  // pair sequencer and the second bit waiting behind the first
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg second_bit_reg;
  reg second_bit_next;

  // output stage next values
  reg code_bit_next;
  reg code_valid_next;
  reg code_first_next;

  // window after a new bit enters stage one and the oldest falls off
  function [`STAGE_COUNT-1:0] shift_in;
    input [`STAGE_COUNT-1:0] stages;
    input new_bit;
    begin
      shift_in = {new_bit, stages[`STAGE_COUNT-1:1]};
    end
  endfunction

  // first generator pattern for the requested mode
  function [`STAGE_COUNT-1:0] first_gen_for;
    input systematic;
    begin
      if (systematic)
        first_gen_for = `GEN_FIRST_SYS;
      else
        first_gen_for = `GEN_FIRST_NONSYS;
    end
  endfunction

  // modulo-2 sum of the stages picked by a generator pattern
  function parity_of;
    input [`STAGE_COUNT-1:0] stages;
    input [`STAGE_COUNT-1:0] gen;
    begin
      parity_of = ^(stages & gen);
    end
  endfunction

  reset_sync u_reset_sync (
    .clk(sys_clk),
    .rst_in_b(rst_b),
    .rst_out_b(rst_sync_b)
  );

  bit_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH),
    .PTR_W(`FIFO_PTR_W)
  ) u_bit_fifo (
    .clk(sys_clk),
    .rst_b(rst_sync_b),
    .in_data(data_bit),
    .in_valid(data_valid),
    .in_ready(data_ready),
    .out_data(fifo_bit),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready)
  );

  // the output slot is free when empty or when its bit leaves this cycle
  assign out_free = !code_valid || code_ready;

  // a new bit is taken only when no pair is pending and the output slot frees
  assign fifo_ready = (state_reg == ST_IDLE) && out_free && !sync_clear;
  assign take = fifo_valid && fifo_ready;

  // the second bit of a pair follows as soon as the first is accepted
  assign send_second = (state_reg == ST_SECOND) && out_free && !sync_clear;

  assign window = shift_in(shift_reg, fifo_bit);
  assign first_parity = parity_of(window, gen_first_reg);
  assign second_parity = parity_of(window, `GEN_SECOND);

  always @*
  begin
    shift_next = shift_reg;
    if (take)
    begin
      // newest bit enters stage one, oldest falls off stage three
      shift_next = window;
    end
  end

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (take)
        begin
          state_next = ST_SECOND;
        end
      end
      ST_SECOND:
      begin
        if (send_second)
        begin
          state_next = ST_IDLE;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @*
  begin
    second_bit_next = second_bit_reg;
    if (take)
    begin
      second_bit_next = second_parity;
    end
  end

  always @*
  begin
    code_bit_next = code_bit;
    code_valid_next = code_valid;
    code_first_next = code_first;
    if (code_valid && code_ready)
    begin
      code_valid_next = 1'h0;
    end
    if (take)
    begin
      // first-generator bit leads the pair
      code_bit_next = first_parity;
      code_valid_next = 1'h1;
      code_first_next = 1'h1;
    end
    else if (send_second)
    begin
      // second bit of the pair follows before any later pair
      code_bit_next = second_bit_reg;
      code_valid_next = 1'h1;
      code_first_next = 1'h0;
    end
  end

  always @*
  begin
    gen_first_next = gen_first_reg;
    mode_next = mode_active;
    if (sync_clear)
    begin
      // generator set latched only here so a live change has no effect
      gen_first_next = first_gen_for(systematic_mode);
      mode_next = systematic_mode;
    end
  end

  always @(posedge sys_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      shift_reg <= `SHIFT_RESET;
    end
    else if (sync_clear)
    begin
      shift_reg <= `SHIFT_RESET;
    end
    else
    begin
      shift_reg <= shift_next;
    end
  end

  always @(posedge sys_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      state_reg <= ST_IDLE;
    end
    else if (sync_clear)
    begin
      state_reg <= ST_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  always @(posedge sys_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      second_bit_reg <= 1'h0;
    end
    else if (sync_clear)
    begin
      second_bit_reg <= 1'h0;
    end
    else
    begin
      second_bit_reg <= second_bit_next;
    end
  end

  always @(posedge sys_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      gen_first_reg <= `GEN_FIRST_NONSYS;
    end
    else
    begin
      gen_first_reg <= gen_first_next;
    end
  end

  always @(posedge sys_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      mode_active <= 1'h0;
    end
    else
    begin
      mode_active <= mode_next;
    end
  end

  always @(posedge sys_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      code_valid <= 1'h0;
    end
    else if (sync_clear)
    begin
      code_valid <= 1'h0;
    end
    else
    begin
      code_valid <= code_valid_next;
    end
  end

  always @(posedge sys_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      code_bit <= 1'h0;
      code_first <= 1'h0;
    end
    else if (sync_clear)
    begin
      code_bit <= 1'h0;
      code_first <= 1'h0;
    end
    else
    begin
      code_bit <= code_bit_next;
      code_first <= code_first_next;
    end
  end
endmodule

// [inc/conv_enc_defs.vh]
// constants for the rate one-half convolutional encoder
`ifndef CONV_ENC_DEFS_VH
`define CONV_ENC_DEFS_VH
`define STAGE_COUNT 3
`define GEN_FIRST_NONSYS 3'h7
`define GEN_FIRST_SYS 3'h4
`define GEN_SECOND 3'h5
`define SHIFT_RESET 3'h0
`define FIFO_WIDTH 1
`define FIFO_DEPTH 8
`define FIFO_PTR_W 3
`endif

// [verilog/bit_fifo.v]
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ns
module bit_fifo #(
  parameter WIDTH = 1,
  parameter DEPTH = 8,
  parameter PTR_W = 3
) (
  input wire clk,
  input wire rst_b,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [PTR_W-1:0] wr_ptr_reg;
  reg [PTR_W-1:0] rd_ptr_reg;
  reg [PTR_W:0] count_reg;
  reg [PTR_W:0] count_next;
  reg in_ready_reg;
  wire push;
  wire pop;

  // ready is registered from the next fill level so the port comes from a flip-flop
  assign in_ready = in_ready_reg;
  assign out_valid = (count_reg != {(PTR_W+1){1'b0}});
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @*
  begin
    count_next = count_reg;
    if (push && !pop)
      count_next = count_reg + 1'b1;
    else if (pop && !push)
      count_next = count_reg - 1'b1;
  end

  always @(posedge clk)
  begin
    if (push)
      mem_reg[wr_ptr_reg] <= in_data;
  end

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr_reg <= {PTR_W{1'b0}};
      rd_ptr_reg <= {PTR_W{1'b0}};
      count_reg <= {(PTR_W+1){1'b0}};
      in_ready_reg <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[PTR_W-1:0] - 1'b1) ? {PTR_W{1'b0}} : wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[PTR_W-1:0] - 1'b1) ? {PTR_W{1'b0}} : rd_ptr_reg + 1'b1;
      count_reg <= count_next;
      in_ready_reg <= (count_next != DEPTH[PTR_W:0]);
    end
  end
endmodule

// [verilog/reset_sync.v]
// two flip-flop release synchroniser for the active low reset
`timescale 1ns/1ns
module reset_sync (
  input wire clk,
  input wire rst_in_b,
  output wire rst_out_b
);
  reg meta_reg;
  reg sync_reg;

  always @(posedge clk or negedge rst_in_b)
  begin
    if (!rst_in_b)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= 1'b1;
      sync_reg <= meta_reg;
    end
  end

  assign rst_out_b = sync_reg;
endmodule

// [test/enc_checker_properties.sv]
// port assertions for the encoder
`timescale 1ns/1ns
module enc_checker (
  input wire sys_clk,
  input wire rst_b,
  input wire sync_clear,
  input wire systematic_mode,
  input wire data_ready,
  input wire code_bit,
  input wire code_valid,
  input wire code_first,
  input wire code_ready,
  input wire mode_active
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_stall_hold: assert property (code_valid && !code_ready && !sync_clear
    |=> code_valid && $stable({code_bit, code_first})) else $error("stalled bit moved");
  a_pair_second: assert property (code_valid && code_ready && code_first && !sync_clear
    |=> code_valid && !code_first) else $error("second bit missing");
  a_pair_next: assert property (code_valid && code_ready && !code_first |=> !code_valid || code_first)
    else $error("extra second bit");
  a_second_after: assert property (code_valid && !code_first |-> $past(code_valid))
    else $error("lone second bit");
  a_mode_latch: assert property (sync_clear |=> mode_active == $past(systematic_mode))
    else $error("mode not latched");
  a_mode_hold: assert property (!sync_clear |=> $stable(mode_active)) else $error("mode moved");
  a_clear_out: assert property (sync_clear |=> !code_valid) else $error("clear kept output");
  a_ready_up: assert property ($rose(rst_b) |-> !data_ready ##[1:3] data_ready)
    else $error("ready late");
  cover property (code_valid && code_ready);
  cover property (code_valid && !code_ready);
  cover property (mode_active);
endmodule
bind rate_half_convolutional_encoder enc_checker enc_checker_i (.*);

// [test/code_sink.sv]
// downstream model, prompt or taking one cycle in four
`timescale 1ns/1ns
module code_sink (
  input wire sys_clk,
  input wire slow,
  input wire code_bit,
  input wire code_valid,
  input wire code_first,
  output wire code_ready
);
  logic [1:0] cnt = 2'h0;
  logic [1:0] got[$];
  assign code_ready = !slow || cnt == 2'h3;
  always @(posedge sys_clk)
  begin
    cnt <= cnt + 2'h1;
    if (code_valid && code_ready)
      got.push_back({code_first, code_bit});
  end
endmodule

// [test/testbench.sv]
// encoder bench
`timescale 1ns/1ns
module testbench;
  logic sys_clk = 0, rst_b = 0, sync_clear = 0, systematic_mode = 0, data_bit = 0, data_valid = 0, slow = 0;
  wire data_ready, code_bit, code_valid, code_first, code_ready, mode_active;
  int failures = 0, num_checks = 0;
  logic [1:0] q[$];
  logic [2:0] s;
  rate_half_convolutional_encoder rate_half_convolutional_encoder_i (.*);
  code_sink code_sink_i (.*);
  initial forever #4 sys_clk = ~sys_clk;
  task cmp(input string nm, input logic [7:0] e, g);
    num_checks++;
    if (g !== e) $display("Error %s exp %h got %h", nm, e, g);
    failures += (g !== e);
  endtask
  task close_out;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task run(input logic [31:0] x, input int n, input logic sys, sl);
    s = 3'h0;
    slow = sl;
    q = {};
    code_sink_i.got = {};
    sync_clear = 1'h1;
    systematic_mode = sys;
    @(negedge sys_clk) sync_clear = 1'h0;
    systematic_mode = !sys;
    data_valid = 1'h1;
    for (int i = n - 1; i >= 0; i--)
    begin
      s = {s[1:0], x[i]};
      q.push_back({1'h1, sys ? x[i] : ^s});
      q.push_back({1'h0, s[2] ^ s[0]});
      data_bit = x[i];
      while (!data_ready) @(negedge sys_clk);
      @(negedge sys_clk);
    end
    data_valid = 1'h0;
    repeat (400) if (code_sink_i.got.size() < 2 * n) @(negedge sys_clk);
    cmp("mode", sys, mode_active);
    cmp("count", 8'(2 * n), 8'(code_sink_i.got.size()));
    foreach (q[i]) cmp("pair", q[i], code_sink_i.got[i]);
  endtask
  task t_known; run(32'h17, 6, 0, 0); endtask
  task t_impulse; run(32'h10, 5, 0, 0); endtask
  task t_sys; run(32'h2d3, 10, 1, 0); endtask
  task t_full; run(32'hc5a396e1, 32, 0, 1); endtask
  initial
  begin
    repeat (16) @(negedge sys_clk);
    rst_b = 1'h1;
    repeat (4) @(negedge sys_clk);
    t_known();
    t_impulse();
    t_sys();
    t_full();
    close_out();
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    close_out();
  end
endmodule
